// File: rsd_ctrl.sv
// What this block does
// RL1: Select bit picks primary input
// RL2: Manual mode: select pin chooses source
// RL3: Manual switch is glitch free
// RL4: Auto: switch after two silent secondary cycles
// RL5: Auto is revertive to present primary
// RL6: Host: auto only with crystal input primary
// RL7: Switching is asynchronous to references
// RL8: Host: external ref keeps load 00h, drive 11h
// RL9: Seven-bit reference, twelve-bit feedback dividers
// RL10: First PLL multiplier 2N+A+1 or 2N
// RL11: Fout equals Fin times M over D over divide
// RL12: Output divider prescale and count decode
// RL13: Disabled divider forces high, low or hi-z
// RL14: First output undivided; other banks divided
// RL15: Host: disable divider only for unused bank
// RL16: Spread on when step period nonzero
// RL17: Host: step period only 5 to 14
// RL18: Quadrant samples mirrored; values 1 to 6
// RL19: Offset zero centres, nonzero gives down spread
// RL20: Spread offset accepts 0 to 63
// RL21: Host: delta sum at most 63 minus offset
// RL22: Amplitude-double doubles summed delta samples
// RL23: Step period plus two, samples times two
// RL24: Detector counts secondary, clears on primary
// RL25: Divider counter resets when disabled or changed
`timescale 1ns/1ps
`include "rsd_map.svh"
module rsd_ctrl
    import rsd_pkg::*;
#(
    parameter int BANKS = 6
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic crystal_ref_input,
    input wire logic aux_clock_input,
    input wire rsd_refcfg_t ref_cfg,
    input wire logic [6:0] ref_divide,
    input wire logic [11:0] feedback_count,
    input wire logic [3:0] frac_adder,
    input wire rsd_ssccfg_t ssc_cfg,
    input wire rsd_odcfg_t [BANKS-1:0] bank_cfg,
    output logic ref_sel_secondary,
    output logic ref_clk_sel,
    output logic primary_absent,
    output logic [13:0] total_multiplier,
    output logic [6:0] ref_divider_out,
    output logic ssc_enable,
    output logic [5:0] ssc_step_period,
    output logic [3:0] ssc_sample_count,
    output logic [6:0] ssc_delta_total,
    output logic [6:0] ssc_centre_frac,
    output logic ssc_down_spread,
    output logic first_output,
    output logic [BANKS-1:0] bank_out,
    output logic [BANKS-1:0] bank_oe,
    output logic [BANKS-1:0] bank_disabled
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] xin_sync;
        logic [1:0] aux_sync;
        logic [1:0] sel_sync;
        logic xin_last;
        logic aux_last;
        logic [1:0] absent_cnt;
        logic absent;
        logic use_secondary;
        logic ref_mux;
        logic [13:0] mult;
        logic [6:0] rdiv;
        logic ssc_en;
        logic [5:0] tstep;
        logic [3:0] nsamp;
        logic [6:0] dsum;
        logic [6:0] centre;
        logic down;
        logic lvl_first;
        logic [3:0] lfsr;
    } rsd_state_t;

    rsd_state_t st_r;
    rsd_state_t st_nxt;
    logic prim_lvl;
    logic sec_lvl;
    logic prim_edge;
    logic sec_edge;
    logic sec_tog;
    logic auto_mode;
    logic [BANKS-1:0] bank_out_w;
    logic [BANKS-1:0] bank_oe_w;
    logic [BANKS-1:0] bank_dis_w;

    // ------------------------------------------------------------------
    // Reference selection and absence detection
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Second stage only is read by logic
        st_nxt.xin_sync = {st_r.xin_sync[0], crystal_ref_input};
        st_nxt.aux_sync = {st_r.aux_sync[0], aux_clock_input};
        st_nxt.sel_sync = {st_r.sel_sync[0], ref_cfg.input_select_pin};
        st_nxt.xin_last = st_r.xin_sync[1];
        st_nxt.aux_last = st_r.aux_sync[1];

        prim_lvl = ref_cfg.primary_source_select ? st_r.aux_sync[1]
                                                 : st_r.xin_sync[1]; // RL1
        sec_lvl = ref_cfg.primary_source_select ? st_r.xin_sync[1]
                                                : st_r.aux_sync[1]; // RL1
        prim_edge = ref_cfg.primary_source_select
                  ? (st_r.aux_sync[1] != st_r.aux_last)
                  : (st_r.xin_sync[1] != st_r.xin_last);
        // Rising edges of the secondary mark its cycles
        sec_edge = sec_lvl & ~(ref_cfg.primary_source_select
                  ? st_r.xin_last : st_r.aux_last);
        // Dividers count both edges of whichever input is selected
        sec_tog = ref_cfg.primary_source_select
                ? (st_r.xin_sync[1] != st_r.xin_last)
                : (st_r.aux_sync[1] != st_r.aux_last); // RL11
        auto_mode = ref_cfg.switchover_mode[1]; // RL2

        if (prim_edge) begin
            st_nxt.absent_cnt = 2'h0; // RL24
            st_nxt.absent = 1'b0; // RL5
        end else if (sec_edge && st_r.absent_cnt != `RSD_ABSENT_CYCLES) begin
            st_nxt.absent_cnt = st_r.absent_cnt + 2'h1; // RL24
            st_nxt.absent = (st_r.absent_cnt + 2'h1 == `RSD_ABSENT_CYCLES); // RL4
        end

        // Manual: the pin chooses; auto: leave primary only while absent
        st_nxt.use_secondary = auto_mode ? st_nxt.absent
                                         : st_r.sel_sync[1]; // RL2 RL5
        // The mux changes only while both candidates are low, or while the primary is absent and the secondary is low, so the
        // selected level never shows a runt pulse.
        if (st_nxt.use_secondary != st_r.use_secondary) begin
            st_nxt.ref_mux = st_r.ref_mux; // RL3
        end
        if (!prim_lvl && !sec_lvl) begin
            st_nxt.ref_mux = st_r.use_secondary; // RL3 RL7
        end
        st_nxt.lvl_first = st_r.ref_mux ? sec_lvl : prim_lvl; // RL14
        // A dead primary cannot reach the low-low window: force handover
        if (st_r.absent && !sec_lvl) begin
            st_nxt.ref_mux = st_r.use_secondary; // RL7
        end

        // --------------------------------------------------------------
        // PLL multiplier and spread settings
        // --------------------------------------------------------------
        st_nxt.rdiv = ref_divide; // RL9 RL11
        if (frac_adder != 4'h0) begin
            st_nxt.mult = {1'b0, feedback_count, 1'b0}
                        + {10'h000, frac_adder} + 14'h0001; // RL10
        end else begin
            st_nxt.mult = {1'b0, feedback_count, 1'b0}; // RL10
        end
        st_nxt.ssc_en = (ssc_cfg.tssc != 4'h0); // RL16
        st_nxt.tstep = {2'h0, ssc_cfg.tssc} + `RSD_TSSC_ADD; // RL23
        st_nxt.nsamp = {ssc_cfg.nssc, 1'b0}; // RL23 RL18
        // Dither randomises the delta sum's lsb
        st_nxt.lfsr = {st_r.lfsr[2:0], st_r.lfsr[3] ^ st_r.lfsr[2]};
        if (st_r.lfsr == 4'h0) begin
            st_nxt.lfsr = 4'h1;
        end
        st_nxt.dsum = {1'b0, ssc_cfg.ssc_delta_sum ^
                      {5'h00, ssc_cfg.ssc_dither & st_r.lfsr[0]}};
        if (ssc_cfg.ssc_amplitude_double) begin
            st_nxt.dsum = {st_nxt.dsum[5:0], 1'b0}; // RL22
        end
        // Centre in 1/64 units of M: offset 0 centres on Mnom (64),
        // otherwise on Mnom-1+offset/64.
        st_nxt.down = (ssc_cfg.ss_offset != 6'h00); // RL19
        st_nxt.centre = st_nxt.down ? {1'b0, ssc_cfg.ss_offset}
                                    : `RSD_CENTRE_NOM; // RL19 RL20
        if (!st_nxt.ssc_en) begin
            st_nxt.dsum = 7'h00;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Output banks, each with its own divider
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < BANKS; gi++) begin : g_bank
            rsd_out_div u_div (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .clk_en(st_r.ref_mux ? sec_tog : prim_edge),
                .cfg(bank_cfg[gi]),
                .clk_out(bank_out_w[gi]),
                .clk_oe(bank_oe_w[gi]),
                .disabled(bank_dis_w[gi])
            ); // RL14
        end
    endgenerate

    assign ref_sel_secondary = st_r.use_secondary;
    assign ref_clk_sel = st_r.ref_mux;
    assign primary_absent = st_r.absent;
    assign total_multiplier = st_r.mult;
    assign ref_divider_out = st_r.rdiv;
    assign ssc_enable = st_r.ssc_en;
    assign ssc_step_period = st_r.tstep;
    assign ssc_sample_count = st_r.nsamp;
    assign ssc_delta_total = st_r.dsum;
    assign ssc_centre_frac = st_r.centre;
    assign ssc_down_spread = st_r.down;
    assign first_output = st_r.lvl_first;
    assign bank_out = bank_out_w;
    assign bank_oe = bank_oe_w;
    assign bank_disabled = bank_dis_w;
endmodule : rsd_ctrl

// File: rsd_ctrl_checker.sv
`timescale 1ns/1ps
module rsd_ctrl_checker
    import rsd_pkg::*;
#(
    parameter int BANKS = 6
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire rsd_refcfg_t ref_cfg,
    input wire logic [11:0] feedback_count,
    input wire logic [3:0] frac_adder,
    input wire rsd_ssccfg_t ssc_cfg,
    input wire rsd_odcfg_t [BANKS-1:0] bank_cfg,
    input wire logic ref_sel_secondary,
    input wire logic primary_absent,
    input wire logic [13:0] total_multiplier,
    input wire logic ssc_enable,
    input wire logic [5:0] ssc_step_period,
    input wire logic [3:0] ssc_sample_count,
    input wire logic [6:0] ssc_delta_total,
    input wire logic [6:0] ssc_centre_frac,
    input wire logic [BANKS-1:0] bank_out,
    input wire logic [BANKS-1:0] bank_oe,
    input wire logic [BANKS-1:0] bank_disabled
);
    // ----
    // Checks
    // ----
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Select decisions lag the synchronisers, so let them settle first
    sequence cfg_steady;
        $stable(ref_cfg) [*6];
    endsequence
    sequence bank0_off;
        (bank_cfg[0].q == 7'h7f && !bank_cfg[0].prescale_bit
            && $stable(bank_cfg[0])) [*3];
    endsequence
    chk_mult_value: assert property (
        1'b1 |=> total_multiplier == 14'(2 * $past(feedback_count)
            + ($past(frac_adder) != 4'h0 ? $past(frac_adder) + 1 : 0)))
        else $error("multiplier wrong");
    chk_ssc_on: assert property (
        1'b1 |=> ssc_enable == ($past(ssc_cfg.tssc) != 4'h0))
        else $error("spread enable wrong");
    chk_ssc_timing: assert property (
        1'b1 |=> ssc_step_period == $past(ssc_cfg.tssc) + 6'h02
            && ssc_sample_count == {$past(ssc_cfg.nssc), 1'b0})
        else $error("spread timing wrong");
    chk_delta_double: assert property (
        ssc_cfg.tssc != 4'h0 && !ssc_cfg.ssc_dither |=> ssc_delta_total
            == {1'b0, $past(ssc_cfg.ssc_delta_sum)}
            << $past(ssc_cfg.ssc_amplitude_double))
        else $error("delta total wrong");
    chk_centre_frac: assert property (
        1'b1 |=> ssc_centre_frac == ($past(ssc_cfg.ss_offset) == 6'h00
            ? 7'h40 : {1'b0, $past(ssc_cfg.ss_offset)}))
        else $error("spread centre wrong");
    chk_manual_sel: assert property (
        cfg_steady ##0 !ref_cfg.switchover_mode[1]
            |-> ref_sel_secondary == ref_cfg.input_select_pin)
        else $error("manual select wrong");
    chk_auto_switch: assert property (
        cfg_steady ##0 ref_cfg.switchover_mode[1] && primary_absent
            |-> ref_sel_secondary)
        else $error("absent primary kept");
    chk_auto_revert: assert property (
        cfg_steady ##0 ref_cfg.switchover_mode[1] && $fell(primary_absent)
            |-> ##[0:2] !ref_sel_secondary)
        else $error("no return to primary");
    chk_bank_off: assert property (
        bank0_off |-> bank_disabled[0] && bank_oe[0] ==
            (bank_cfg[0].disabled_output_state != 2'h2) && (!bank_oe[0]
            || bank_out[0] == (bank_cfg[0].disabled_output_state == 2'h1)))
        else $error("disabled bank drive wrong");
endmodule : rsd_ctrl_checker
bind rsd_ctrl rsd_ctrl_checker #(.BANKS(BANKS)) u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .ref_cfg(ref_cfg),
    .feedback_count(feedback_count), .frac_adder(frac_adder),
    .ssc_cfg(ssc_cfg), .bank_cfg(bank_cfg),
    .ref_sel_secondary(ref_sel_secondary),
    .primary_absent(primary_absent), .total_multiplier(total_multiplier),
    .ssc_enable(ssc_enable), .ssc_step_period(ssc_step_period),
    .ssc_sample_count(ssc_sample_count), .ssc_delta_total(ssc_delta_total),
    .ssc_centre_frac(ssc_centre_frac), .bank_out(bank_out),
    .bank_oe(bank_oe), .bank_disabled(bank_disabled));

// File: rsd_ctrl_tb_top.sv
`timescale 1ns/1ps
module rsd_ctrl_tb_top;
    import rsd_pkg::*;
    // ----
    // Bench
    // ----
    logic ref_clk, resetn, run_a, xt, ax, sec, gone, fo, en, mux, ds;
    rsd_refcfg_t rc;
    rsd_ssccfg_t ss;
    rsd_odcfg_t [5:0] bc;
    logic [11:0] fb;
    logic [3:0] fa, sc;
    logic [6:0] rd, rdo, dt, cf;
    logic [13:0] tm;
    logic [5:0] sp, bo, boe, bd;
    logic [31:0] seed = 32'h62053170;
    logic [7:0] dcfg [4] = '{8'h80, 8'h05, 8'h81, 8'hff};
    int dv [4] = '{4, 2, 6, 1};
    int failures, comparisons, r, b, e, d;
    rsd_ref_src src (.run_a(run_a), .crys(xt), .aux(ax));
    rsd_ctrl uut (.ref_clk(ref_clk), .resetn(resetn),
        .crystal_ref_input(xt), .aux_clock_input(ax), .ref_cfg(rc),
        .ref_divide(rd), .feedback_count(fb), .frac_adder(fa),
        .ssc_cfg(ss), .bank_cfg(bc), .ref_sel_secondary(sec),
        .ref_clk_sel(mux), .primary_absent(gone), .total_multiplier(tm),
        .ref_divider_out(rdo), .ssc_enable(en), .ssc_step_period(sp),
        .ssc_sample_count(sc), .ssc_delta_total(dt),
        .ssc_centre_frac(cf), .ssc_down_spread(ds), .first_output(fo),
        .bank_out(bo), .bank_oe(boe), .bank_disabled(bd));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task check(input string nm, input int e, input logic [13:0] g);
        comparisons++;
        if (g !== 14'(e)) begin
            failures++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask : check
    task wait_n(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask : wait_n
    task count(input int n);
        logic pf, pb;
        r = 0;
        b = 0;
        pf = fo;
        pb = bo[0];
        repeat (n) begin
            wait_n(1);
            r += fo && !pf;
            b += bo[0] && !pb;
            pf = fo;
            pb = bo[0];
        end
    endtask : count
    task give_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        failures++;
        give_verdict();
    end
    initial begin
        resetn = 1'b0;
        run_a = 1'b1;
        rc = '0;
        rd = 7'h01;
        fb = 12'h016;
        fa = 4'h3;
        ss = '0;
        bc = {6{10'h200}};
        wait_n(6);
        resetn = 1'b1;
        for (int i = 0; i < 40; i++) begin
            fb = 12'(rnd());
            fa = i == 1 ? 4'h0 : 4'(rnd());
            rd = 7'(rnd());
            ss = rsd_ssccfg_t'(21'(rnd()));
            ss.ssc_dither = i[2];
            if (i < 2) ss.ss_offset = i ? 6'h00 : 6'h3f;
            // Host keeps step period 5..14 (0 turns spread off), quadrant
            // samples 1..6 and the delta sum within the offset's room
            ss.tssc = i % 5 == 3 ? 4'h0 : 4'(5 + rnd() % 10);
            ss.nssc = 3'(1 + rnd() % 6);
            ss.ssc_delta_sum = 6'(rnd() % (64 - ss.ss_offset));
            wait_n(2);
            d = ss.tssc == 0 ? 0
                : ss.ssc_delta_sum * (ss.ssc_amplitude_double + 1);
            // Dither may flip the sum's lsb before the doubling
            e = ss.tssc == 0 ? 0
                : (ss.ssc_delta_sum ^ 1) * (ss.ssc_amplitude_double + 1);
            check("multiplier", fa != 0 ? 2 * fb + fa + 1 : 2 * fb, tm);
            check("ref divider", rd, rdo);
            check("spread enable", ss.tssc != 0, en);
            check("step period", ss.tssc + 2, sp);
            check("sample count", ss.nssc * 2, sc);
            if (ss.ssc_dither)
                check("dither delta", 1, dt == d || dt == e);
            else
                check("delta total", d, dt);
            check("centre", ss.ss_offset == 0 ? 64 : ss.ss_offset, cf);
            check("down spread", ss.ss_offset != 0, ds);
        end
        for (int k = 0; k < 4; k++) begin
            rc = {k[1], 2'b00, k[0]};
            bc[0] = {dcfg[k], 2'h0};
            wait_n(24);
            check("secondary select", k[0], sec);
            count(240);
            e = k[1] ^ k[0] ? 20 : 30;
            check("reference rises", 1, r >= e - 1 && r <= e + 1);
            e = b * dv[k] - r;
            check("bank ratio", 1, e >= -dv[k] && e <= dv[k]);
            check("reference mux", k[0], mux);
        end
        for (int j = 0; j < 6; j++) begin
            for (int s = 0; s < 3; s++) begin
                bc[j] = {1'b0, 7'h7f, 2'(s)};
                wait_n(4);
                check("bank disabled", 1, bd[j]);
                check("bank enable", s != 2, boe[j]);
                if (s != 2) check("bank level", s, bo[j]);
            end
            bc[j] = 10'h200;
            wait_n(4);
            check("bank disabled", 0, bd[j]);
        end
        rc = 4'b0100;
        wait_n(20);
        check("absent", 0, gone);
        run_a = 1'b0;
        wait_n(8);
        check("early switch", 0, sec);
        wait_n(30);
        check("absent", 1, gone);
        check("secondary select", 1, sec);
        run_a = 1'b1;
        wait_n(20);
        check("secondary select", 0, sec);
        give_verdict();
    end
endmodule : rsd_ctrl_tb_top

// File: rsd_map.svh
`ifndef RSD_MAP_SVH
`define RSD_MAP_SVH
`define RSD_ABSENT_CYCLES 2'h2
`define RSD_Q_ALL_ONES 7'h7f
`define RSD_TSSC_ADD 6'h02
`define RSD_NSSC_MUL 1
`define RSD_DIS_LOW 2'h0
`define RSD_DIS_HIGH 2'h1
`define RSD_DIS_HIZ 2'h2
`define RSD_Q_ADD 8'h02
`define RSD_DIV2_HALF 9'h002
`define RSD_CENTRE_NOM 7'h40
`define RSD_SSC_ADDR_FIRST 8'hac
`define RSD_SSC_ADDR_LAST 8'hbd
`define RSD_OFFSET_MAX 6'h3f
`endif

// File: rsd_out_div.sv
`timescale 1ns/1ps
`include "rsd_map.svh"
module rsd_out_div
    import rsd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire rsd_odcfg_t cfg,
    output logic clk_out,
    output logic clk_oe,
    output logic disabled
);
    // --------------------------------------------------------------
    // Divider decode and counter
    // --------------------------------------------------------------
    typedef struct packed {
        logic [8:0] cnt;
        logic out;
        logic oe;
        logic dis;
        rsd_odcfg_t cfg_last;
    } rsd_od_state_t;

    rsd_od_state_t st_r;
    rsd_od_state_t st_nxt;
    rsd_divmode_t mode;
    logic [8:0] half;

    function automatic rsd_divmode_t rsd_decode(input rsd_odcfg_t c);
        if (c.q == `RSD_Q_ALL_ONES)
            return c.prescale_bit ? RSD_DIV_1 : RSD_DIV_OFF; // RL12
        return c.prescale_bit ? RSD_DIV_Q : RSD_DIV_2; // RL12
    endfunction : rsd_decode

    always_comb begin
        mode = rsd_decode(cfg);
        // Half period in selected-reference edges: an input cycle has two
        // edges, so /2 needs 2 and /((q+2)*2) needs (q+2)*2.
        half = (mode == RSD_DIV_Q) ? {({1'b0, cfg.q} + `RSD_Q_ADD), 1'b0}
                                   : `RSD_DIV2_HALF; // RL12
        st_nxt = st_r;
        st_nxt.cfg_last = cfg;
        st_nxt.dis = (mode == RSD_DIV_OFF);
        if (cfg != st_r.cfg_last || mode == RSD_DIV_OFF) begin
            st_nxt.cnt = 9'h000; // RL25
        end else if (clk_en) begin
            unique case (mode)
                RSD_DIV_1: st_nxt.out = ~st_r.out;
                default: begin
                    if (st_r.cnt + 9'h001 >= half) begin
                        st_nxt.cnt = 9'h000;
                        st_nxt.out = ~st_r.out;
                    end else begin
                        st_nxt.cnt = st_r.cnt + 9'h001;
                    end
                end
            endcase
        end
        if (mode == RSD_DIV_OFF) begin
            // Stays powered; only the pin level is forced
            st_nxt.oe = (cfg.disabled_output_state != `RSD_DIS_HIZ); // RL13
            st_nxt.out = (cfg.disabled_output_state == `RSD_DIS_HIGH); // RL13
        end else begin
            st_nxt.oe = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign clk_out = st_r.out;
    assign clk_oe = st_r.oe;
    assign disabled = st_r.dis;
endmodule : rsd_out_div

// File: rsd_pkg.sv
package rsd_pkg;
    typedef enum logic [1:0] {RSD_DIV_OFF, RSD_DIV_1, RSD_DIV_2, RSD_DIV_Q}
        rsd_divmode_t;
    typedef struct packed {
        logic primary_source_select;
        logic [1:0] switchover_mode;
        logic input_select_pin;
    } rsd_refcfg_t;
    typedef struct packed {
        logic [3:0] tssc;
        logic [2:0] nssc;
        logic [5:0] ss_offset;
        logic [5:0] ssc_delta_sum;
        logic ssc_dither;
        logic ssc_amplitude_double;
    } rsd_ssccfg_t;
    typedef struct packed {
        logic prescale_bit;
        logic [6:0] q;
        logic [1:0] disabled_output_state;
    } rsd_odcfg_t;
endpackage : rsd_pkg

// File: rsd_ref_src.sv
`timescale 1ns/1ps
module rsd_ref_src (
    input wire logic run_a,
    output logic crys,
    output logic aux
);
    // Aux is kept slower than the crystal; a stopped source holds level
    // An external reference on the crystal input: load code 00h, drive 11h
    initial begin
        crys = 1'b0;
        forever #200 if (run_a) crys = ~crys;
    end
    initial begin
        aux = 1'b0;
        forever #300 aux = ~aux;
    end
endmodule : rsd_ref_src
